// ==== core/i2c_stop_regs.vh ====
// Register offsets, field positions and reset values for the stop sequencer.
// Assumes a byte-addressed plain register port with 8-bit addresses.
`ifndef I2C_STOP_REGS_VH
`define I2C_STOP_REGS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define REG_CONTROL 8'h00
`define REG_BAUD 8'h04
`define REG_BUFFER 8'h08
`define REG_STATUS 8'h0c
`define REG_IRQ_STATUS 8'h10
`define REG_IRQ_MASK 8'h14

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CTL_STOP_SEQ_ENABLE 0
`define CTL_ACK_SEQ_ENABLE 1
`define CTL_ACK_DATA_VALUE 2
`define STS_STOP_DETECTED 0
`define STS_WRITE_COLLISION 1
`define STS_BUSY 2
`define IRQ_SERIAL_PORT 0
`define IRQ_COLLISION 1

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define BAUD_RESET 8'h04
`define MASK_RESET 2'h0
`define BUFFER_RESET 8'h00

`endif

// ==== core/baud_counter.v ====
// Reload counter that times one baud-rate period of the stop sequencer.
// Assumes a synchronous load pulse from logic on the same clock.
`timescale 1ns/1ps

module baud_counter (
   // Clock and reset.
   input wire clock,
   input wire reset,
   // Control.
   input wire load,
   input wire [7:0] reload,
   // Timeout pulse, one cycle, reload plus one cycles after the load.
   output reg expired
);

   reg [7:0] count_q;
   reg running_q;

   // ----------------------------------------------------------------------
   // Countdown
   // ----------------------------------------------------------------------
   // A new load restarts the period, so a late reload never doubles up.
   always @(posedge clock) begin
      if (reset) begin
         count_q <= 8'h00;
         running_q <= 1'b0;
         expired <= 1'b0;
      end else if (load) begin
         count_q <= reload;
         running_q <= 1'b1;
         expired <= 1'b0;
      end else if (running_q && count_q == 8'h00) begin
         running_q <= 1'b0;
         expired <= 1'b1;
      end else begin
         expired <= 1'b0;
         if (running_q) begin
            count_q <= count_q - 8'h01;
         end
      end
   end

endmodule // baud_counter

// ==== core/i2c_stop_sequencer.v ====
// Master stop-condition and acknowledge sequencer for a two-wire bus,
// with a plain register port and a level interrupt.
// Assumes open-drain pads outside: an enable high pulls the line low, and
// the sampled line levels arrive asynchronously and are synchronised here.
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "i2c_stop_regs.vh"

// Function
// - Buffer write during acknowledge sets collision, dropped
// - Clock held low after ninth clock
// - Stop enable drives data line low first
// - Data sampled low reloads baud counter
// - Counter expiry releases clock line
// - One period later release data line
// - Data high while clock high sets stop
// - Period later clear enable, set interrupt
// - Buffer write during stop sets collision, dropped
// - Acknowledge sequence drives data, clears enable
module i2c_stop_sequencer (
   // Clock and reset.
   input wire clock,
   input wire reset,
   // Register port.
   input wire [7:0] addr,
   input wire [7:0] wdata,
   input wire wr_stb,
   input wire rd_stb,
   output reg [7:0] rdata,
   // Transfer engine: pulse at the ninth falling clock edge of a byte.
   input wire xfer_end,
   // Bus lines, open drain.
   input wire scl_in,
   output reg scl_out,
   output reg scl_oe,
   input wire sda_in,
   output reg sda_out,
   output reg sda_oe,
   // Interrupt, level.
   output reg irq
);

   // ----------------------------------------------------------------------
   // Sequencer states
   // ----------------------------------------------------------------------
   localparam [3:0] ST_IDLE = 4'h0;
   localparam [3:0] ST_ACK_LOW = 4'h1;
   localparam [3:0] ST_ACK_RISE = 4'h2;
   localparam [3:0] ST_ACK_HIGH = 4'h3;
   localparam [3:0] ST_STOP_SDA = 4'h4;
   localparam [3:0] ST_STOP_WAIT = 4'h5;
   localparam [3:0] ST_STOP_SCL = 4'h6;
   localparam [3:0] ST_STOP_REL = 4'h7;
   localparam [3:0] ST_STOP_DET = 4'h8;
   localparam [3:0] ST_STOP_END = 4'h9;

   reg [3:0] state_q;
   reg [3:0] state_d;
   reg stop_seq_enable_q;
   reg ack_seq_enable_q;
   reg ack_data_value_q;
   reg [7:0] baud_q;
   reg [7:0] serial_xfer_buffer_q;
   reg stop_detected_q;
   reg write_collision_flag_q;
   reg [1:0] irq_status_q;
   reg [1:0] irq_mask_q;
   reg hold_clock_q;
   reg scl_meta_q;
   reg scl_sync_q;
   reg sda_meta_q;
   reg sda_sync_q;
   reg load_d;
   reg scl_drive_d;
   reg sda_drive_d;
   reg stop_done_d;
   reg ack_done_d;
   reg stop_seen_d;
   reg [7:0] rdata_d;
   wire expired;
   wire busy;
   wire buf_write;
   wire collision;

   // Register access decode.
   function hit;
      input [7:0] a;
      input [7:0] offset;
      input stb;
      begin
         hit = stb && (a == offset);
      end
   endfunction

   // ----------------------------------------------------------------------
   // Line synchronisers
   // ----------------------------------------------------------------------
   // The lines may change at any time, so each passes two flip-flops.
   always @(posedge clock) begin
      if (reset) begin
         scl_meta_q <= 1'b1;
         scl_sync_q <= 1'b1;
         sda_meta_q <= 1'b1;
         sda_sync_q <= 1'b1;
      end else begin
         scl_meta_q <= scl_in;
         scl_sync_q <= scl_meta_q;
         sda_meta_q <= sda_in;
         sda_sync_q <= sda_meta_q;
      end
   end

   // ----------------------------------------------------------------------
   // Baud-rate period timer
   // ----------------------------------------------------------------------
   baud_counter u_baud (
      .clock(clock),
      .reset(reset),
      .load(load_d),
      .reload(baud_q),
      .expired(expired)
   );

   assign busy = (state_q != ST_IDLE);
   assign buf_write = hit(addr, `REG_BUFFER, wr_stb);
   assign collision = buf_write && busy;

   // ----------------------------------------------------------------------
   // Sequencer next state
   // ----------------------------------------------------------------------
   // Waits on the sampled lines mean that a slave stretching the clock, or
   // another master holding data low, simply delays the step that waits on that line.
   always @* begin
      state_d = state_q;
      load_d = 1'b0;
      scl_drive_d = hold_clock_q;
      sda_drive_d = 1'b0;
      stop_done_d = 1'b0;
      ack_done_d = 1'b0;
      stop_seen_d = 1'b0;
      case (state_q)
         ST_IDLE: begin
            if (ack_seq_enable_q) begin
               state_d = ST_ACK_LOW;
               load_d = 1'b1;
            end else if (stop_seq_enable_q) begin
               state_d = ST_STOP_SDA;
            end
         end
         ST_ACK_LOW: begin
            scl_drive_d = 1'b1;
            sda_drive_d = ~ack_data_value_q;
            if (expired) begin
               state_d = ST_ACK_RISE;
            end
         end
         ST_ACK_RISE: begin
            scl_drive_d = 1'b0;
            sda_drive_d = ~ack_data_value_q;
            if (scl_sync_q) begin
               state_d = ST_ACK_HIGH;
               load_d = 1'b1;
            end
         end
         ST_ACK_HIGH: begin
            scl_drive_d = 1'b0;
            sda_drive_d = ~ack_data_value_q;
            if (expired) begin
               state_d = ST_IDLE;
               scl_drive_d = 1'b1;
               ack_done_d = 1'b1;
            end
         end
         ST_STOP_SDA: begin
            scl_drive_d = 1'b1;
            sda_drive_d = 1'b1;
            if (!sda_sync_q) begin
               state_d = ST_STOP_WAIT;
               load_d = 1'b1;
            end
         end
         ST_STOP_WAIT: begin
            scl_drive_d = 1'b1;
            sda_drive_d = 1'b1;
            if (expired) begin
               state_d = ST_STOP_SCL;
               scl_drive_d = 1'b0;
            end
         end
         ST_STOP_SCL: begin
            scl_drive_d = 1'b0;
            sda_drive_d = 1'b1;
            if (scl_sync_q) begin
               state_d = ST_STOP_REL;
               load_d = 1'b1;
            end
         end
         ST_STOP_REL: begin
            scl_drive_d = 1'b0;
            sda_drive_d = 1'b1;
            if (expired) begin
               state_d = ST_STOP_DET;
               sda_drive_d = 1'b0;
            end
         end
         ST_STOP_DET: begin
            scl_drive_d = 1'b0;
            if (sda_sync_q && scl_sync_q) begin
               state_d = ST_STOP_END;
               load_d = 1'b1;
               stop_seen_d = 1'b1;
            end
         end
         ST_STOP_END: begin
            scl_drive_d = 1'b0;
            if (expired) begin
               state_d = ST_IDLE;
               stop_done_d = 1'b1;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // Sequencer state and line drivers
   // ----------------------------------------------------------------------
   // The pads only ever pull low; a released line rises by its pull-up.
   always @(posedge clock) begin
      if (reset) begin
         state_q <= ST_IDLE;
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
         scl_out <= 1'b0;
         sda_out <= 1'b0;
      end else begin
         state_q <= state_d;
         scl_oe <= scl_drive_d;
         sda_oe <= sda_drive_d;
         scl_out <= 1'b0;
         sda_out <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Clock hold after a byte
   // ----------------------------------------------------------------------
   // The hold ends only when the stop sequence lets the clock rise.
   always @(posedge clock) begin
      if (reset) begin
         hold_clock_q <= 1'b0;
      end else if (xfer_end || ack_done_d) begin
         hold_clock_q <= 1'b1;
      end else if (state_q == ST_STOP_WAIT && expired) begin
         hold_clock_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------------
   // Hardware clears an enable only when its own sequence finishes; in that
   // cycle the clear overrides a software write of the same enable bit.
   always @(posedge clock) begin
      if (reset) begin
         stop_seq_enable_q <= 1'b0;
         ack_seq_enable_q <= 1'b0;
         ack_data_value_q <= 1'b0;
      end else begin
         if (hit(addr, `REG_CONTROL, wr_stb)) begin
            stop_seq_enable_q <= wdata[`CTL_STOP_SEQ_ENABLE];
            ack_seq_enable_q <= wdata[`CTL_ACK_SEQ_ENABLE];
            ack_data_value_q <= wdata[`CTL_ACK_DATA_VALUE];
         end
         if (stop_done_d) begin
            stop_seq_enable_q <= 1'b0;
         end
         if (ack_done_d) begin
            ack_seq_enable_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Baud reload and transfer buffer
   // ----------------------------------------------------------------------
   // A buffer write while a sequence runs is discarded outright.
   always @(posedge clock) begin
      if (reset) begin
         baud_q <= `BAUD_RESET;
         serial_xfer_buffer_q <= `BUFFER_RESET;
      end else begin
         if (hit(addr, `REG_BAUD, wr_stb)) begin
            baud_q <= wdata;
         end
         if (buf_write && !busy) begin
            serial_xfer_buffer_q <= wdata;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Status flags
   // ----------------------------------------------------------------------
   // Writing a one clears a flag, but a new event in the same cycle wins.
   always @(posedge clock) begin
      if (reset) begin
         stop_detected_q <= 1'b0;
         write_collision_flag_q <= 1'b0;
      end else begin
         if (stop_seen_d) begin
            stop_detected_q <= 1'b1;
         end else if (hit(addr, `REG_STATUS, wr_stb) &&
                      wdata[`STS_STOP_DETECTED]) begin
            stop_detected_q <= 1'b0;
         end
         if (collision) begin
            write_collision_flag_q <= 1'b1;
         end else if (hit(addr, `REG_STATUS, wr_stb) &&
                      wdata[`STS_WRITE_COLLISION]) begin
            write_collision_flag_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Interrupt status, mask and output
   // ----------------------------------------------------------------------
   always @(posedge clock) begin
      if (reset) begin
         irq_status_q <= 2'h0;
         irq_mask_q <= `MASK_RESET;
         irq <= 1'b0;
      end else begin
         if (hit(addr, `REG_IRQ_MASK, wr_stb)) begin
            irq_mask_q <= wdata[1:0];
         end
         if (stop_done_d) begin
            irq_status_q[`IRQ_SERIAL_PORT] <= 1'b1;
         end else if (hit(addr, `REG_IRQ_STATUS, wr_stb) &&
                      wdata[`IRQ_SERIAL_PORT]) begin
            irq_status_q[`IRQ_SERIAL_PORT] <= 1'b0;
         end
         if (collision) begin
            irq_status_q[`IRQ_COLLISION] <= 1'b1;
         end else if (hit(addr, `REG_IRQ_STATUS, wr_stb) &&
                      wdata[`IRQ_COLLISION]) begin
            irq_status_q[`IRQ_COLLISION] <= 1'b0;
         end
         // One cycle behind the status bits, so the output is a flop.
         irq <= |(irq_status_q & irq_mask_q);
      end
   end

   // ----------------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------------
   // Unmapped addresses read as zero; read data stand one cycle only.
   always @* begin
      rdata_d = 8'h00;
      case (addr)
         `REG_CONTROL: begin
            rdata_d = {5'h00, ack_data_value_q, ack_seq_enable_q,
                       stop_seq_enable_q};
         end
         `REG_BAUD: begin
            rdata_d = baud_q;
         end
         `REG_BUFFER: begin
            rdata_d = serial_xfer_buffer_q;
         end
         `REG_STATUS: begin
            rdata_d = {5'h00, busy, write_collision_flag_q, stop_detected_q};
         end
         `REG_IRQ_STATUS: begin
            rdata_d = {6'h00, irq_status_q};
         end
         `REG_IRQ_MASK: begin
            rdata_d = {6'h00, irq_mask_q};
         end
         default: begin
            rdata_d = 8'h00;
         end
      endcase
   end

   always @(posedge clock) begin
      if (reset) begin
         rdata <= 8'h00;
      end else if (rd_stb) begin
         rdata <= rdata_d;
      end else begin
         rdata <= 8'h00;
      end
   end

endmodule // i2c_stop_sequencer

// ==== dv/i2c_stop_sequencer_sva.sv ====
// Checker for the stop sequencer's bus pins and register port.
// Assumes open-drain pads with pull-ups and a baud reload of at least 4.
`timescale 1ns/1ps
`include "i2c_stop_regs.vh"

module i2c_stop_sequencer_chk (
   // Clock and reset.
   input wire clock,
   input wire reset,
   // Register port.
   input wire [7:0] addr,
   input wire [7:0] wdata,
   input wire wr_stb,
   input wire rd_stb,
   input wire [7:0] rdata,
   // Bus lines and interrupt.
   input wire xfer_end,
   input wire scl_in,
   input wire scl_out,
   input wire scl_oe,
   input wire sda_in,
   input wire sda_out,
   input wire sda_oe,
   input wire irq
);
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   // A stop request made while the data line is free.
   sequence stop_req;
      wr_stb && addr == `REG_CONTROL && wdata[1:0] == 2'b01 && !sda_oe;
   endsequence
   // Both lines pulled low together, the opening step of a stop.
   sequence both_low;
      sda_oe && scl_oe;
   endsequence

   chk_rdata_idle: assert property (!$past(rd_stb) |-> rdata == 8'h00)
      else $error("read data not zero outside a read");
   chk_pins_low: assert property (!scl_out && !sda_out)
      else $error("bus output data not low");
   chk_stop_first: assert property (stop_req |-> ##3 both_low)
      else $error("data line not pulled low after stop request");
   chk_hold_low: assert property (xfer_end |-> ##2 scl_oe [*4])
      else $error("clock line not held after byte end");
   chk_scl_release: assert property ($fell(scl_oe) && sda_oe |->
      $past(sda_oe, 4) && !sda_in)
      else $error("clock released before data low and a period");
   chk_sda_release: assert property ($fell(sda_oe) && !scl_oe |->
      scl_in && !$past(scl_oe, 4))
      else $error("data released too early in stop");
   chk_start_hold: assert property ($rose(sda_oe) |-> scl_oe [*5])
      else $error("clock not held while data driven");
   chk_irq_fall: assert property ($fell(irq) |-> $past(wr_stb, 2))
      else $error("interrupt dropped without a write");
endmodule // i2c_stop_sequencer_chk

bind i2c_stop_sequencer i2c_stop_sequencer_chk chk_u (.clock(clock),
   .reset(reset), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
   .rd_stb(rd_stb), .rdata(rdata), .xfer_end(xfer_end), .scl_in(scl_in),
   .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));

// ==== dv/i2c_bus_slave.sv ====
// Slave side of the two-wire bus: pull-ups, wired lines and a clock
// stretch that the bench commands. Assumes pad enables pull low.
`timescale 1ns/1ps

module i2c_bus_slave (
   // Pad enables of the master.
   input wire scl_oe,
   input wire sda_oe,
   // Stretch length in 800 ns bus clocks, started by a rising go.
   input wire [3:0] stretch_clocks,
   input wire stretch_go,
   // Line levels seen by the master.
   output wire scl_line,
   output wire sda_line
);
   reg hold_q = 1'b0;

   // Holding the clock low makes the master wait, as a slow slave would.
   always @(posedge stretch_go) begin
      hold_q = 1'b1;
      #(800 * stretch_clocks);
      hold_q = 1'b0;
   end

   // Released lines float high; the pad delay keeps samples off the edge.
   assign #15 scl_line = !(scl_oe || hold_q);
   assign #15 sda_line = !sda_oe;
endmodule // i2c_bus_slave

// ==== dv/tb_i2c_master_stop_sequencer.sv ====
// Self-checking bench: registers, byte end, stop and acknowledge
// sequences, collisions and the interrupt. Assumes the slave model.
`timescale 1ns/1ps
`include "i2c_stop_regs.vh"

module tb_i2c_master_stop_sequencer;
   reg clock, reset, wr_stb, rd_stb, xfer_end, go, rd_seen;
   reg [7:0] addr, wdata, baud, data;
   reg [3:0] span;
   wire [7:0] rdata;
   wire scl_in, scl_out, scl_oe, sda_in, sda_out, sda_oe, irq;
   logic [7:0] exp_q[$];
   logic [7:0] rst_a [7] = '{`REG_CONTROL, `REG_BAUD, `REG_BUFFER,
      `REG_STATUS, `REG_IRQ_STATUS, `REG_IRQ_MASK, 8'h1c};
   logic [7:0] rst_v [7] = '{8'h00, `BAUD_RESET, `BUFFER_RESET, 8'h00,
      8'h00, 8'h00, 8'h00};
   int mismatches, checked, n;
   int both_n = 0, low_n = 0;

   i2c_stop_sequencer dut_u (.clock(clock), .reset(reset), .addr(addr),
      .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
      .xfer_end(xfer_end), .scl_in(scl_in), .scl_out(scl_out),
      .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out),
      .sda_oe(sda_oe), .irq(irq));
   i2c_bus_slave slave_u (.scl_oe(scl_oe), .sda_oe(sda_oe),
      .stretch_clocks(span), .stretch_go(go), .scl_line(scl_in),
      .sda_line(sda_in));

   // ---------------------------------------------------------------
   // Clock, tasks and read monitor
   // ---------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   task automatic check(input string name, input logic [7:0] seen,
      input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic close_out;
      if (mismatches == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge clock);
      wr_stb <= 1'b0;
   endtask

   // The expected value is queued before the strobe goes out.
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      @(posedge clock);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clock);
      rd_stb <= 1'b0;
   endtask

   // Bounded wait on the interrupt or the clock pad enable.
   task automatic wait_for(input bit use_irq, input logic v);
      logic s;
      n = 0;
      s = use_irq ? irq : scl_oe;
      while (s !== v && n < 300) begin
         @(posedge clock);
         s = use_irq ? irq : scl_oe;
         n++;
      end
      check(use_irq ? "irq" : "scl_oe", {7'h00, s}, {7'h00, v});
   endtask

   // Read data stands only in the cycle after the strobe.
   always @(posedge clock) rd_seen <= rd_stb;
   always @(negedge clock) begin
      if (rd_seen === 1'b1)
         check("rdata", rdata, exp_q.pop_front());
   end

   // Length of the last run with both pads pulling low, so the stop's
   // wait for the data line and one baud period can be measured.
   always @(posedge clock) begin
      if (sda_oe && scl_oe)
         both_n <= both_n + 1;
      else if (both_n != 0) begin
         low_n <= both_n;
         both_n <= 0;
      end
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      {reset, wr_stb, rd_stb, xfer_end, go} = 5'h10;
      {addr, wdata, span} = 20'h00000;
      data = 8'($urandom(49215));
      baud = 8'h04 + 8'($urandom % 4);
      span = 4'd5 + 4'($urandom % 4);
      repeat (6) @(posedge clock);
      reset <= 1'b0;
      foreach (rst_a[i]) rd(rst_a[i], rst_v[i]);
      wr(`REG_BAUD, baud);
      wr(`REG_BUFFER, data);
      wr(`REG_IRQ_MASK, 8'h01);
      wr(8'h1c, 8'hff);
      rd(`REG_BAUD, baud);
      rd(`REG_BUFFER, data);
      rd(8'h1c, 8'h00);
      // Byte end, then a stop while the slave stretches the clock.
      @(posedge clock);
      xfer_end <= 1'b1;
      @(posedge clock);
      xfer_end <= 1'b0;
      repeat (4) @(posedge clock);
      check("scl_oe", {7'h00, scl_oe}, 8'h01);
      go <= 1'b1;
      wr(`REG_CONTROL, 8'h01);
      wr(`REG_BUFFER, ~data);
      go <= 1'b0;
      repeat (20) @(posedge clock);
      check("sda_oe", {7'h00, sda_oe}, 8'h01);
      wait_for(1'b1, 1'b1);
      check("sda_oe", {7'h00, sda_oe}, 8'h00);
      check("scl_oe", {7'h00, scl_oe}, 8'h00);
      check("low_n", 8'(low_n), baud + 8'h05);
      rd(`REG_STATUS, 8'h03);
      rd(`REG_BUFFER, data);
      rd(`REG_CONTROL, 8'h00);
      rd(`REG_IRQ_STATUS, 8'h03);
      wr(`REG_STATUS, 8'h03);
      wr(`REG_IRQ_STATUS, 8'h03);
      rd(`REG_STATUS, 8'h00);
      rd(`REG_IRQ_STATUS, 8'h00);
      check("irq", {7'h00, irq}, 8'h00);
      // Acknowledge with each data value, a buffer write in the middle.
      for (int v = 0; v < 2; v++) begin
         wr(`REG_CONTROL, {5'h00, v[0], 2'b10});
         wr(`REG_BUFFER, data + 8'h01);
         @(negedge clock);
         check("sda_oe", {7'h00, sda_oe}, {7'h00, ~v[0]});
         check("scl_oe", {7'h00, scl_oe}, 8'h01);
         wait_for(1'b0, 1'b0);
         wait_for(1'b0, 1'b1);
         rd(`REG_CONTROL, {5'h00, v[0], 2'b00});
         rd(`REG_BUFFER, data);
         rd(`REG_STATUS, 8'h02);
         wr(`REG_STATUS, 8'h02);
      end
      // A masked collision event shows only once unmasked.
      rd(`REG_IRQ_STATUS, 8'h02);
      check("irq", {7'h00, irq}, 8'h00);
      wr(`REG_IRQ_MASK, 8'h02);
      @(posedge clock);
      @(negedge clock);
      check("irq", {7'h00, irq}, 8'h01);
      wr(`REG_IRQ_STATUS, 8'h02);
      @(posedge clock);
      @(negedge clock);
      check("irq", {7'h00, irq}, 8'h00);
      repeat (2) @(posedge clock);
      close_out();
   end

   // Watchdog: the run needs far fewer than 20000 cycles.
   initial begin
      #(100 * 20000);
      mismatches++;
      close_out();
   end
endmodule // tb_i2c_master_stop_sequencer
